// ===== audio_pkg.sv
package audio_pkg;

  // Clock and sample-rate figures.
  localparam logic [63:0] CLK_HZ             = 64'h0000_0000_0773_5940; // 125 MHz.
  localparam logic [63:0] SAMPLE_HZ          = 64'h0000_0000_0000_BB80; // 48 kHz.
  localparam logic [63:0] TICKS_PER_SAMPLE   = 64'h0000_0000_0000_0200; // Two ticks per MCLK.
  localparam logic [63:0] NCO_STEP_WIDE      = ((SAMPLE_HZ * TICKS_PER_SAMPLE) << 32) / CLK_HZ;
  localparam logic [31:0] NCO_STEP_NOM       = NCO_STEP_WIDE[31:0]; // Nominal phase step.
  localparam logic [1:0]  TICKS_PER_SCK_HALF = 2'h3;                // SCK toggles every 4 ticks.

  // Start-of-frame timing: nominal interval in microseconds and in cycles.
  localparam logic [63:0] SOF_PERIOD_US      = 64'h0000_0000_0000_03E8; // 1 ms.
  localparam logic [63:0] US_PER_S           = 64'h0000_0000_000F_4240;
  localparam logic [31:0] SOF_PERIOD_CYCLES  = 32'((SOF_PERIOD_US * CLK_HZ) / US_PER_S);
  localparam logic [6:0]  SYNC_WINDOW_FRAMES = 7'h40; // Frames averaged per measurement.

  // Adaptive trim figures.
  localparam logic signed [31:0] TRIM_STEP  = 32'sh0000_0100;
  localparam logic signed [31:0] TRIM_LIMIT = 32'sh0010_0000;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] WATER_OFF    = 8'h04;
  localparam logic [7:0] PKT_LEN_OFF  = 8'h08;
  localparam logic [7:0] STATUS_OFF   = 8'h0C;
  localparam logic [7:0] TRIM_OFF     = 8'h10;
  localparam logic [7:0] IN_DATA_OFF  = 8'h14;
  localparam logic [7:0] OUT_DATA_OFF = 8'h18;

  // Field positions and reset values.
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_MODE_LSB    = 1;
  localparam int STAT_OUT_FILL    = 8;
  localparam int STAT_PKT_LSB     = 16;
  localparam int STAT_MIC_BIT     = 24;
  localparam int STAT_OVR_BIT     = 25;
  localparam int STAT_UNR_BIT     = 26;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] WATER_RST   = 32'h0000_3010; // High 48, low 16 words.
  localparam logic [31:0] PKT_LEN_RST = 32'h0031_302F; // High 49, mid 48, low 47.

  // FIFO geometry.
  localparam int FIFO_AW = 6;

  // Rate-matching mode written by software.
  typedef enum logic [1:0] {
    RATE_ASYNC    = 2'b00,
    RATE_ADAPTIVE = 2'b01,
    RATE_SYNC     = 2'b10
  } rate_mode_type;

  // Where a FIFO fill sits against its water marks.
  typedef enum logic [1:0] {
    ZONE_LOW  = 2'b00,
    ZONE_MID  = 2'b01,
    ZONE_HIGH = 2'b10
  } zone_type;

  // One stereo sample pair as it moves through the FIFOs.
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } stereo_type;

  // Water marks shared by both FIFOs.
  typedef struct packed {
    logic [15:0] unused;
    logic [7:0]  high;
    logic [7:0]  low;
  } water_type;

  // Packet lengths per fill zone.
  typedef struct packed {
    logic [7:0] unused;
    logic [7:0] high;
    logic [7:0] mid;
    logic [7:0] low;
  } pkt_len_type;

endpackage : audio_pkg

// ===== skid_buffer.sv
`timescale 1ns/1ns
`default_nettype none

// Two-entry buffer; it accepts a word whenever a slot is free, so the
// source can keep streaming for one cycle after the sink stalls.
module skid_buffer
  import audio_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] slot_q [2]; // Slot 0 is always the head.
  logic [1:0]       count_q;    // Words held, 0 to 2.
  logic             push;
  logic             pop;

  assign push      = in_valid && (count_q != 2'h2);
  assign pop       = out_ready && (count_q != 2'h0);
  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = slot_q[0];

  // Occupancy follows pushes and pops; both may happen in one cycle.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count_q <= 2'h0;
    else
      count_q <= count_q + 2'(push) - 2'(pop);
  end

  // On a pop the tail moves to the head; a push lands on the first free slot.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
    end
    else
    begin
      if (pop)
        slot_q[0] <= slot_q[1];
      if (push)
      begin
        if (count_q == 2'h0 || (count_q == 2'h1 && pop))
          slot_q[0] <= in_data;
        else
          slot_q[1] <= in_data;
      end
    end
  end

endmodule : skid_buffer

`default_nettype wire

// ===== audio_serial_rate_control.sv
`timescale 1ns/1ns
`default_nettype none

module audio_serial_rate_control
  import audio_pkg::*;
#(
  parameter logic [31:0] FRAME_CYCLES = SOF_PERIOD_CYCLES // Cycles per 1 ms frame.
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic        sof_pulse,
  input  wire logic        audio_serial_data_in,
  output logic             audio_serial_data_out,
  output logic             audio_channel_select_clock,
  output logic             audio_bit_clock,
  output logic             audio_master_clock,
  input  wire logic        microphone_plug_detect,
  output logic [7:0]       frame_packet_length
);

  localparam int          DEPTH       = 1 << FIFO_AW;
  localparam logic [31:0] WINDOW_CYC  = FRAME_CYCLES * 32'(SYNC_WINDOW_FRAMES);
  localparam logic [31:0] SYNC_GAIN   = NCO_STEP_NOM / WINDOW_CYC;

  // Classify a fill level against the two water marks.
  function automatic zone_type fill_zone(input logic [FIFO_AW:0] fill,
                                         input water_type        marks);
    if ({1'b0, fill} > marks.high)
      fill_zone = ZONE_HIGH;
    else if ({1'b0, fill} < marks.low)
      fill_zone = ZONE_LOW;
    else
      fill_zone = ZONE_MID;
  endfunction : fill_zone

  // Byte-lane merge of a bus write into a register.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    for (int i = 0; i < 4; i++)
      lane_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
  endfunction : lane_merge

  logic [31:0]        ctrl_q;        // Enable and rate mode.
  water_type          water_q;       // Water marks.
  pkt_len_type        pkt_len_q;     // Packet lengths per zone.
  logic               overrun_q;     // IN FIFO dropped a sample.
  logic               underrun_q;    // Transmitter found no word.
  logic               req;           // New bus request this cycle.
  logic               wr_req;
  logic               rd_req;
  logic               enable;
  rate_mode_type      rate_mode;
  logic [31:0]        rd_data;       // Read mux.

  // IN and OUT FIFO storage and pointers.
  stereo_type         in_mem [DEPTH];
  stereo_type         out_mem [DEPTH];
  logic [FIFO_AW-1:0] in_wr_q, in_rd_q, out_wr_q, out_rd_q;
  logic [FIFO_AW:0]   in_cnt_q, out_cnt_q;
  logic               in_push, in_pop, out_push, out_pop;

  // Buffer between OUT FIFO and the transmitter.
  logic               buf_in_ready;
  logic               buf_out_valid;
  stereo_type         buf_out_data;
  logic               tx_load;

  // Clock generation and serial framing state.
  logic [31:0]        nco_acc_q;
  logic signed [31:0] trim_q;
  logic [31:0]        nco_step;
  logic [32:0]        nco_sum;
  logic               tick;
  logic [1:0]         div_q;
  logic               sck_fall, sck_rise;
  logic [5:0]         bit_q;         // Bit position in 64-bit frame.
  logic [5:0]         next_bit;
  logic [4:0]         slot_pos;
  stereo_type         tx_word_q;
  logic [15:0]        rx_left_q, rx_right_q;

  // Frame-marker measurement.
  logic               meas_run_q;
  logic [31:0]        meas_cnt_q;
  logic [6:0]         meas_sofs_q;
  logic               window_done;
  logic signed [31:0] sync_diff;

  assign enable    = ctrl_q[CTRL_EN_BIT];
  assign rate_mode = rate_mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req    = req && wb_we_i;
  assign rd_req    = req && !wb_we_i;

  // Ack one cycle after the request and drop it the cycle after.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // Read mux; unmapped offsets and an empty IN FIFO read as zero.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case ({wb_adr_i[7:2], 2'b00})
      CTRL_OFF:    rd_data = ctrl_q;
      WATER_OFF:   rd_data = water_q;
      PKT_LEN_OFF: rd_data = pkt_len_q;
      STATUS_OFF:
      begin
        rd_data[FIFO_AW:0]                      = in_cnt_q;
        rd_data[STAT_OUT_FILL +: FIFO_AW+1]     = out_cnt_q;
        rd_data[STAT_PKT_LSB +: 8]              = frame_packet_length;
        rd_data[STAT_MIC_BIT]                   = microphone_plug_detect;
        rd_data[STAT_OVR_BIT]                   = overrun_q;
        rd_data[STAT_UNR_BIT]                   = underrun_q;
      end
      TRIM_OFF:    rd_data = trim_q;
      IN_DATA_OFF: rd_data = (in_cnt_q != '0) ? in_mem[in_rd_q] : 32'h0000_0000;
      default:     rd_data = 32'h0000_0000;
    endcase
  end

  // Read data is captured with the ack so it comes from a flip-flop.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wb_dat_o <= 32'h0000_0000;
    else if (rd_req)
      wb_dat_o <= rd_data;
  end

  // Configuration registers honour byte selects.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q    <= CTRL_RST;
      water_q   <= WATER_RST;
      pkt_len_q <= PKT_LEN_RST;
    end
    else if (wr_req)
    begin
      case ({wb_adr_i[7:2], 2'b00})
        CTRL_OFF:    ctrl_q    <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0007;
        WATER_OFF:   water_q   <= lane_merge(water_q, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
        PKT_LEN_OFF: pkt_len_q <= lane_merge(pkt_len_q, wb_dat_i, wb_sel_i) & 32'h00FF_FFFF;
        default:     ctrl_q    <= ctrl_q;
      endcase
    end
  end

  // Sticky error flags; write one to clear, a new event in the same cycle wins.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      overrun_q  <= 1'b0;
      underrun_q <= 1'b0;
    end
    else
    begin
      if (in_push && in_cnt_q == (FIFO_AW+1)'(DEPTH))
        overrun_q <= 1'b1;
      else if (wr_req && {wb_adr_i[7:2], 2'b00} == STATUS_OFF && wb_sel_i[3]
               && wb_dat_i[STAT_OVR_BIT])
        overrun_q <= 1'b0;
      if (tx_load && !buf_out_valid)
        underrun_q <= 1'b1;
      else if (wr_req && {wb_adr_i[7:2], 2'b00} == STATUS_OFF && wb_sel_i[3]
               && wb_dat_i[STAT_UNR_BIT])
        underrun_q <= 1'b0;
    end
  end

  // IN FIFO: the receiver pushes every finished pair, the bus pops.
  assign in_pop  = rd_req && {wb_adr_i[7:2], 2'b00} == IN_DATA_OFF && in_cnt_q != '0;
  assign in_push = tx_load;

  // A full IN FIFO drops the new pair; the overrun flag records it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_wr_q  <= '0;
      in_rd_q  <= '0;
      in_cnt_q <= '0;
    end
    else
    begin
      if (in_push && in_cnt_q != (FIFO_AW+1)'(DEPTH))
      begin
        in_mem[in_wr_q] <= {rx_left_q, rx_right_q};
        in_wr_q         <= in_wr_q + 1'b1;
      end
      if (in_pop)
        in_rd_q <= in_rd_q + 1'b1;
      in_cnt_q <= in_cnt_q + (FIFO_AW+1)'(in_push && in_cnt_q != (FIFO_AW+1)'(DEPTH))
                  - (FIFO_AW+1)'(in_pop);
    end
  end

  // OUT FIFO: host data arrives by bus writes and drains into the buffer.
  assign out_push = wr_req && {wb_adr_i[7:2], 2'b00} == OUT_DATA_OFF
                    && out_cnt_q != (FIFO_AW+1)'(DEPTH);
  assign out_pop  = buf_in_ready && out_cnt_q != '0;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_wr_q  <= '0;
      out_rd_q  <= '0;
      out_cnt_q <= '0;
    end
    else
    begin
      if (out_push)
      begin
        out_mem[out_wr_q] <= wb_dat_i;
        out_wr_q          <= out_wr_q + 1'b1;
      end
      if (out_pop)
        out_rd_q <= out_rd_q + 1'b1;
      out_cnt_q <= out_cnt_q + (FIFO_AW+1)'(out_push) - (FIFO_AW+1)'(out_pop);
    end
  end

  // The buffer stalls the OUT FIFO until the transmitter takes a word.
  skid_buffer #(
    .WIDTH     (32)
  ) u_tx_buffer (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (out_cnt_q != '0),
    .in_ready  (buf_in_ready),
    .in_data   (out_mem[out_rd_q]),
    .out_valid (buf_out_valid),
    .out_ready (tx_load),
    .out_data  (buf_out_data)
  );

  // Once per frame marker, pick the packet length from the IN fill.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      frame_packet_length <= 8'h00;
    else if (sof_pulse)
    begin
      case (fill_zone(in_cnt_q, water_q))
        ZONE_HIGH: frame_packet_length <= pkt_len_q.high;
        ZONE_LOW:  frame_packet_length <= pkt_len_q.low;
        default:   frame_packet_length <= pkt_len_q.mid;
      endcase
    end
  end

  // Measure the cycles spanned by a window of frame markers; averaging
  // over many frames cancels the per-frame jitter of the host.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meas_run_q  <= 1'b0;
      meas_cnt_q  <= 32'h0000_0000;
      meas_sofs_q <= 7'h00;
    end
    else if (rate_mode != RATE_SYNC)
      meas_run_q <= 1'b0;
    else if (sof_pulse)
    begin
      meas_run_q  <= 1'b1;
      meas_cnt_q  <= (meas_run_q && !window_done) ? meas_cnt_q + 32'h1 : 32'h0000_0001;
      meas_sofs_q <= (meas_run_q && !window_done) ? meas_sofs_q + 7'h01 : 7'h01;
    end
    else if (meas_run_q)
      meas_cnt_q <= meas_cnt_q + 32'h1;
  end

  assign window_done = meas_run_q && sof_pulse && meas_sofs_q == SYNC_WINDOW_FRAMES;
  assign sync_diff   = $signed(WINDOW_CYC) - $signed(meas_cnt_q);

  // Trim of the phase step: zero in async mode, stepped per frame in
  // adaptive mode, computed from the host rate in sync mode.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      trim_q <= 32'sh0000_0000;
    else
    begin
      case (rate_mode)
        RATE_ASYNC:
          trim_q <= 32'sh0000_0000;
        RATE_ADAPTIVE:
          if (sof_pulse)
          begin
            case (fill_zone(out_cnt_q, water_q))
              ZONE_HIGH: if (trim_q < TRIM_LIMIT) trim_q <= trim_q + TRIM_STEP;
              ZONE_LOW:  if (trim_q > -TRIM_LIMIT) trim_q <= trim_q - TRIM_STEP;
              default:   trim_q <= trim_q;
            endcase
          end
        RATE_SYNC:
          if (window_done)
            trim_q <= 32'(sync_diff * $signed(SYNC_GAIN));
        default:
          trim_q <= 32'sh0000_0000;
      endcase
    end
  end

  // Phase accumulator: a carry is one tick at twice the master clock rate.
  // A shorter measured window (fast host) gives a larger step.
  assign nco_step = NCO_STEP_NOM + trim_q;
  assign nco_sum  = {1'b0, nco_acc_q} + {1'b0, nco_step};
  assign tick     = enable && nco_sum[32];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      nco_acc_q <= 32'h0000_0000;
    else if (enable)
      nco_acc_q <= nco_sum[31:0];
    else
      nco_acc_q <= 32'h0000_0000;
  end

  // Master clock toggles each tick; bit clock every fourth tick.
  assign sck_fall = tick && div_q == TICKS_PER_SCK_HALF && audio_bit_clock;
  assign sck_rise = tick && div_q == TICKS_PER_SCK_HALF && !audio_bit_clock;
  assign next_bit = bit_q + 6'h01;
  assign slot_pos = next_bit[4:0];
  assign tx_load  = sck_fall && next_bit == 6'h00;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      audio_master_clock <= 1'b0;
      audio_bit_clock    <= 1'b0;
      div_q              <= 2'h0;
    end
    else if (!enable)
    begin
      audio_master_clock <= 1'b0;
      audio_bit_clock    <= 1'b0;
      div_q              <= 2'h0;
    end
    else if (tick)
    begin
      audio_master_clock <= !audio_master_clock;
      div_q              <= div_q + 2'h1;
      if (div_q == TICKS_PER_SCK_HALF)
        audio_bit_clock <= !audio_bit_clock;
    end
  end

  // Transmit on the falling bit clock edge: channel clock changes one bit
  // ahead of each 16-bit MSB-first sample in a 32-bit slot.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_q                      <= 6'h3F;
      audio_channel_select_clock <= 1'b1;
      audio_serial_data_out      <= 1'b0;
      tx_word_q                  <= '0;
    end
    else if (!enable)
    begin
      bit_q                      <= 6'h3F;
      audio_channel_select_clock <= 1'b1;
      audio_serial_data_out      <= 1'b0;
    end
    else if (sck_fall)
    begin
      bit_q                      <= next_bit;
      audio_channel_select_clock <= next_bit[5];
      audio_serial_data_out      <= 1'b0;
      if (tx_load)
        tx_word_q <= buf_out_valid ? buf_out_data : '0;
      if (slot_pos >= 5'h01 && slot_pos <= 5'h10)
      begin
        if (next_bit[5])
          audio_serial_data_out <= tx_word_q.right[4'(5'h10 - slot_pos)];
        else
          audio_serial_data_out <= tx_word_q.left[4'(5'h10 - slot_pos)];
      end
    end
  end

  // Receive on the rising bit clock edge, MSB first, into the slot's channel.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_left_q  <= 16'h0000;
      rx_right_q <= 16'h0000;
    end
    else if (sck_rise && bit_q[4:0] >= 5'h01 && bit_q[4:0] <= 5'h10)
    begin
      if (bit_q[5])
        rx_right_q <= {rx_right_q[14:0], audio_serial_data_in};
      else
        rx_left_q  <= {rx_left_q[14:0], audio_serial_data_in};
    end
  end

endmodule : audio_serial_rate_control

`default_nettype wire

// ===== audio_serial_rate_control_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Port timing of the bus handshake and of the serial audio link.
module audio_serial_rate_control_properties
  import audio_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       sof_pulse,
  input wire logic       audio_serial_data_out,
  input wire logic       audio_channel_select_clock,
  input wire logic       audio_bit_clock,
  input wire logic       audio_master_clock,
  input wire logic [7:0] frame_packet_length
);
  logic [5:0] falls_q;  // Bit clock falls since the last slot change.
  logic       primed_q; // Set once a slot change was seen.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Counts bit periods in a slot; it saturates so a stuck channel clock cannot wrap it.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      falls_q  <= 6'h00;
      primed_q <= 1'b0;
    end
    else
    begin
      primed_q <= primed_q | $changed(audio_channel_select_clock);
      if ($changed(audio_channel_select_clock))
        falls_q <= 6'h00;
      else if ($fell(audio_bit_clock) && falls_q != 6'h3F)
        falls_q <= falls_q + 6'h01;
    end
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  AST_PKT_ON_SOF: assert property (
    $changed(frame_packet_length) |-> $past(sof_pulse) || $past(sof_pulse, 2))
    else $error("packet length moved without a frame marker");
  AST_MCLK_ALIGN: assert property (
    $changed(audio_bit_clock) |-> $changed(audio_master_clock))
    else $error("bit clock moved off a master clock tick");
  AST_SDO_ON_FALL: assert property (
    $changed(audio_serial_data_out) |-> $fell(audio_bit_clock))
    else $error("data out moved off a falling bit clock");
  AST_LR_ON_FALL: assert property (
    $changed(audio_channel_select_clock) |-> $fell(audio_bit_clock))
    else $error("channel clock moved off a falling bit clock");
  AST_SLOT_LEN: assert property (
    $changed(audio_channel_select_clock) && primed_q |-> falls_q == 6'h1F)
    else $error("slot is not 32 bit periods");
  AST_SDO_PAD: assert property (
    $changed(audio_channel_select_clock) || falls_q > 6'h10 |-> !audio_serial_data_out)
    else $error("data out not zero outside sample bits");
endmodule : audio_serial_rate_control_properties
bind audio_serial_rate_control audio_serial_rate_control_properties chk (.clk, .rst_b,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sof_pulse, .audio_serial_data_out,
  .audio_channel_select_clock, .audio_bit_clock, .audio_master_clock, .frame_packet_length);
`default_nettype wire

// ===== codec_model.sv
`timescale 1ns/1ns
`default_nettype none
// Codec model: plays pairs onto the data input line and records what it hears.
module codec_model
(
  input  wire logic bit_clk,
  input  wire logic chan_clk,
  input  wire logic sdo,
  output var logic  sdi
);
  logic [31:0] tx_q[$];       // Pairs still to send, left in the upper half.
  logic [31:0] rx_q[$];       // Pairs heard from the device.
  logic [31:0] tx_w = 32'h0;  // Pair being sent.
  logic [31:0] rx_w = 32'h0;  // Pair being heard.
  logic        chan_d = 1'b1; // Channel clock at the last falling edge.
  int          bit_n = 0;     // Bit period within the slot.
  initial sdi = 1'b0;
  // Launch just after the fall, once the channel clock has settled.
  always @(negedge bit_clk)
  begin
    #1;
    bit_n = (chan_clk != chan_d) ? 0 : bit_n + 1;
    chan_d = chan_clk;
    if (bit_n == 0 && !chan_clk)
      tx_w = (tx_q.size() > 0) ? tx_q.pop_front() : 32'h0;
    if (bit_n >= 1 && bit_n <= 16)
      sdi = chan_clk ? tx_w[16 - bit_n] : tx_w[32 - bit_n];
    else
      sdi = ~sdi; // Unused bits carry no value, so the line keeps moving.
  end
  // Hear the device on the rising edge, half a bit after its launch.
  always @(posedge bit_clk)
  begin
    if (bit_n >= 1 && bit_n <= 16)
      rx_w = chan_clk ? {rx_w[31:16], rx_w[14:0], sdo} : {rx_w[30:16], sdo, rx_w[15:0]};
    if (bit_n == 16 && chan_clk)
      rx_q.push_back(rx_w);
  end
endmodule : codec_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// Bench for the rate controller: register bus on one side, codec model on the other.
module tb_top
  import audio_pkg::*;
;
  localparam logic [31:0] FC = 32'h0000_00C8; // Short frame keeps sync windows brief.
  logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sof = 1'b0;
  logic        mic = 1'b0, ack, sdo, sdi, lrck, bclk, mclk;
  logic [3:0]  sel = 4'hF; // Whole words only.
  logic [7:0]  adr = 8'h00, pkt;
  logic [31:0] wdat = 32'h0, rdat, rbus, seed = 32'h0000_8216;
  logic [31:0] sent_q[$], cap_q[$]; // Playback and capture pairs, oldest first.
  logic [7:0]  offs[5] = '{CTRL_OFF, WATER_OFF, PKT_LEN_OFF, TRIM_OFF, 8'h1C};
  logic [31:0] rstv[5] = '{CTRL_RST, WATER_RST, PKT_LEN_RST, 32'h0, 32'h0};
  pkt_len_type plen;
  int          mismatches = 0, checked = 0, mrise = 0; // mrise counts master clock rises.
  audio_serial_rate_control #(.FRAME_CYCLES(FC)) uut (.clk, .rst_b, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .sof_pulse(sof), .audio_serial_data_in(sdi),
    .audio_serial_data_out(sdo), .audio_channel_select_clock(lrck), .audio_bit_clock(bclk),
    .audio_master_clock(mclk), .microphone_plug_detect(mic), .frame_packet_length(pkt));
  codec_model codec (.bit_clk(bclk), .chan_clk(lrck), .sdo, .sdi);
  always @(posedge mclk) mrise++;
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // The request stands until ack is sampled high; read data is taken at that edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rbus = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    check("bus ack", 32'(ack), 32'h1);
  endtask : bus
  // One-cycle frame marker, then time for the choice to settle.
  task automatic pulse_sof();
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_sof
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (90000) @(posedge clk); // The tests need about 75000 cycles.
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    mic   <= 1'b1;
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF); // An unmapped write must leave no trace.
    foreach (offs[i])
    begin
      bus(1'b0, offs[i], 32'h0);
      check("reset value", rbus, rstv[i]);
    end
    bus(1'b0, STATUS_OFF, 32'h0);
    check("mic detect", 32'(rbus[STAT_MIC_BIT]), 32'h1);
    // Capture: fill climbs one pair a frame; packet length follows its zone.
    plen = xorshift() & 32'h00FF_FFFF;
    bus(1'b1, PKT_LEN_OFF, plen);
    bus(1'b1, WATER_OFF, 32'h0000_0402);
    repeat (4)
    begin
      cap_q.push_back(xorshift());
      codec.tx_q.push_back(cap_q[$]);
    end
    bus(1'b1, CTRL_OFF, 32'h1);
    for (int f = 1; f <= 7; f++)
    begin
      @(negedge lrck);
      @(posedge clk);
      pulse_sof();
      check("packet length", 32'(pkt), 32'(f > 4 ? plen.high : f < 2 ? plen.low : plen.mid));
    end
    bus(1'b0, TRIM_OFF, 32'h0);
    check("async trim", rbus, 32'h0);
    bus(1'b0, IN_DATA_OFF, 32'h0); // The first push after enable holds no codec pair.
    foreach (cap_q[i])
    begin
      bus(1'b0, IN_DATA_OFF, 32'h0);
      check("capture pair", rbus, cap_q[i]);
    end
    // Playback: empty, between the marks, then above the high mark.
    bus(1'b1, CTRL_OFF, 32'h3);
    bus(1'b0, TRIM_OFF, 32'h0);
    check("adaptive start", rbus, 32'h0);
    for (int s = 0; s < 3; s++)
    begin
      @(negedge lrck);
      @(posedge clk);
      // Two words wait in the buffer ahead of the transmitter, outside the OUT fill,
      // so four words give a fill of two, and four more after one load give five.
      repeat (s == 0 ? 0 : 4)
      begin
        sent_q.push_back(xorshift() | 32'h0001_0001);
        bus(1'b1, OUT_DATA_OFF, sent_q[$]);
      end
      pulse_sof();
      bus(1'b0, TRIM_OFF, 32'h0);
      check("adaptive trim", rbus, s < 2 ? 32'hFFFF_FF00 : 32'h0);
    end
    repeat (9) @(negedge lrck);
    mrise = 0;
    @(negedge lrck);
    check("master clock per frame", 32'(mrise), 32'h0000_0100);
    foreach (codec.rx_q[i])
      if (codec.rx_q[i] !== 32'h0)
        check("playback pair", codec.rx_q[i], sent_q.pop_front());
    check("playback left", 32'(sent_q.size()), 32'h0);
    // Sync: a window at the nominal interval, then one a cycle longer each frame.
    bus(1'b1, CTRL_OFF, 32'h5);
    fork
      for (int f = 0; f < 129; f++)
      begin
        pulse_sof();
        repeat ((f < 64 ? FC : FC + 1) - 4) @(posedge clk);
      end
    join_none
    repeat (64 * FC + 20) @(posedge clk);
    bus(1'b0, TRIM_OFF, 32'h0);
    check("sync trim", rbus, 32'h0);
    repeat (64 * FC + 100) @(posedge clk);
    bus(1'b0, TRIM_OFF, 32'h0);
    check("sync trim sign", 32'(rbus[31]), 32'h1);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
